// File: rtl/gdimd_pkg.sv
// Shared constants and types of the gate drive input mode decoder
package gdimd_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] INPUTS_OFFSET = 8'h08;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ASYNC_BIT = 3;
  localparam int CTRL_STOP_LSB = 4;
  localparam logic [2:0] CTRL_MODE_RESET = 3'h0;
  localparam logic CTRL_ASYNC_RESET = 1'h0;
  localparam logic [1:0] CTRL_STOP_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Status and input register fields
  // ----------------------------------------------------------------
  localparam int STAT_UPPER_LSB = 0;
  localparam int STAT_LOWER_LSB = 3;
  localparam int STAT_BYPASS_LSB = 6;
  localparam int STAT_PERFET_LSB = 9;
  localparam int STAT_MON_UP_LSB = 12;
  localparam int STAT_MON_LO_LSB = 15;
  localparam int IN_UPPER_LSB = 0;
  localparam int IN_LOWER_LSB = 3;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Modes, stop selection, commutation keys, phase masks
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SIX_INPUT = 3'h0,
    MODE_THREE_INPUT = 3'h1,
    MODE_SINGLE_PULSE = 3'h2,
    MODE_HALF_BRIDGE = 3'h3,
    MODE_MIXED_C_FET = 3'h4,
    MODE_MIXED_A_FET = 3'h5,
    MODE_MIXED_BC_FET = 3'h6,
    MODE_INDEP_FET = 3'h7
  } gdimd_mode_e;

  typedef enum logic [1:0] {
    STOP_NONE = 2'h0,
    STOP_BRAKE = 2'h1,
    STOP_COAST = 2'h2
  } gdimd_stop_e;

  localparam logic [2:0] KEY_STOP = 3'h0;
  localparam logic [2:0] KEY_ALIGN = 3'h7;
  localparam logic [2:0] KEY_B_TO_C = 3'h6;
  localparam logic [2:0] KEY_A_TO_C = 3'h4;
  localparam logic [2:0] KEY_A_TO_B = 3'h5;
  localparam logic [2:0] KEY_C_TO_B = 3'h1;
  localparam logic [2:0] KEY_C_TO_A = 3'h3;
  localparam logic [2:0] KEY_B_TO_A = 3'h2;

  localparam logic [2:0] PH_NONE = 3'h0;
  localparam logic [2:0] PH_A = 3'h1;
  localparam logic [2:0] PH_B = 3'h2;
  localparam logic [2:0] PH_C = 3'h4;
  localparam logic [2:0] PH_ALL = 3'h7;

endpackage

// File: rtl/gdimd_commutate.sv
// Six-step commutation table for the single-pulse mode
`timescale 1ns/100ps
module gdimd_commutate
(
  input wire logic pulse,
  input wire logic [2:0] state_bits,
  input wire logic direction,
  input wire logic async_rectify,
  output logic [2:0] upper,
  output logic [2:0] lower
);

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  logic [2:0] key;
  logic [2:0] source;
  logic [2:0] sink;

  // inverted key reverses
  // Stop and align keep their own codes, or reversal would swap them
  assign key = (direction && (state_bits != gdimd_pkg::KEY_STOP) &&
                (state_bits != gdimd_pkg::KEY_ALIGN)) ? ~state_bits : state_bits;

  // Source and sink phases of each entry; stop leaves both empty
  always_comb
  begin
    source = gdimd_pkg::PH_NONE;
    sink = gdimd_pkg::PH_NONE;
    case (key)
      gdimd_pkg::KEY_ALIGN:
      begin
        source = gdimd_pkg::PH_A;
        sink = gdimd_pkg::PH_B | gdimd_pkg::PH_C;
      end
      gdimd_pkg::KEY_B_TO_C:
      begin
        source = gdimd_pkg::PH_B;
        sink = gdimd_pkg::PH_C;
      end
      gdimd_pkg::KEY_A_TO_C:
      begin
        source = gdimd_pkg::PH_A;
        sink = gdimd_pkg::PH_C;
      end
      gdimd_pkg::KEY_A_TO_B:
      begin
        source = gdimd_pkg::PH_A;
        sink = gdimd_pkg::PH_B;
      end
      gdimd_pkg::KEY_C_TO_B:
      begin
        source = gdimd_pkg::PH_C;
        sink = gdimd_pkg::PH_B;
      end
      gdimd_pkg::KEY_C_TO_A:
      begin
        source = gdimd_pkg::PH_C;
        sink = gdimd_pkg::PH_A;
      end
      gdimd_pkg::KEY_B_TO_A:
      begin
        source = gdimd_pkg::PH_B;
        sink = gdimd_pkg::PH_A;
      end
      default:
      begin
        source = gdimd_pkg::PH_NONE;
        sink = gdimd_pkg::PH_NONE;
      end
    endcase
  end

  assign upper = source & {3{pulse}};
  assign lower = sink | (source & {3{~pulse & ~async_rectify}});

endmodule

// File: rtl/gdimd_decoder.sv
// Gate drive input mode decoder with AXI4-Lite control registers
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module gdimd_decoder
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clock_enable,
  input wire logic phase_a_upper_input,
  input wire logic phase_a_lower_input,
  input wire logic phase_b_upper_input,
  input wire logic phase_b_lower_input,
  input wire logic phase_c_upper_input,
  input wire logic phase_c_lower_input,
  output logic [2:0] upper_gate_output,
  output logic [2:0] lower_gate_output,
  output logic [2:0] dead_time_bypass,
  output logic [2:0] per_fet_fault_handling,
  output logic [2:0] drain_source_overcurrent_monitor_upper,
  output logic [2:0] drain_source_overcurrent_monitor_lower,
  input wire logic [gdimd_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gdimd_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gdimd_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gdimd_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // State of the whole block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic aw_held;
    logic [gdimd_pkg::AXI_ADDR_W-1:0] aw_addr;
    logic wready;
    logic w_held;
    logic [gdimd_pkg::AXI_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [gdimd_pkg::AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    gdimd_pkg::gdimd_mode_e mode;
    logic async_rectify;
    logic [1:0] stop_select;
    logic [2:0] upper;
    logic [2:0] lower;
    logic [2:0] bypass;
    logic [2:0] per_fet;
    logic [2:0] mon_upper;
    logic [2:0] mon_lower;
  } gdimd_state_s;

  gdimd_state_s s;
  gdimd_state_s next_s;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Word-aligned address match; the two low address bits are ignored
  function automatic logic addr_is(
    input logic [gdimd_pkg::AXI_ADDR_W-1:0] addr,
    input logic [7:0] offset
  );
    addr_is = (addr[7:2] == offset[7:2]);
  endfunction

  // Phases that run as independent FETs in a given mode
  function automatic logic [2:0] fet_phases(input gdimd_pkg::gdimd_mode_e mode);
    case (mode)
      gdimd_pkg::MODE_MIXED_C_FET: fet_phases = gdimd_pkg::PH_C;
      gdimd_pkg::MODE_MIXED_A_FET: fet_phases = gdimd_pkg::PH_A;
      gdimd_pkg::MODE_MIXED_BC_FET: fet_phases = gdimd_pkg::PH_B | gdimd_pkg::PH_C;
      gdimd_pkg::MODE_INDEP_FET: fet_phases = gdimd_pkg::PH_ALL;
      default: fet_phases = gdimd_pkg::PH_NONE;
    endcase
  endfunction

  // Status word of the decoder's own outputs
  function automatic logic [gdimd_pkg::AXI_DATA_W-1:0] status_word(input gdimd_state_s st);
    logic [gdimd_pkg::AXI_DATA_W-1:0] w;
    w = '0;
    w[gdimd_pkg::STAT_UPPER_LSB +: 3] = st.upper;
    w[gdimd_pkg::STAT_LOWER_LSB +: 3] = st.lower;
    w[gdimd_pkg::STAT_BYPASS_LSB +: 3] = st.bypass;
    w[gdimd_pkg::STAT_PERFET_LSB +: 3] = st.per_fet;
    w[gdimd_pkg::STAT_MON_UP_LSB +: 3] = st.mon_upper;
    w[gdimd_pkg::STAT_MON_LO_LSB +: 3] = st.mon_lower;
    status_word = w;
  endfunction

  // ----------------------------------------------------------------
  // Input grouping and the commutation table
  // ----------------------------------------------------------------
  logic [2:0] upper_in;
  logic [2:0] lower_in;
  logic [2:0] table_upper;
  logic [2:0] table_lower;

  // Index 0 is phase A, 1 phase B, 2 phase C
  assign upper_in = {phase_c_upper_input, phase_b_upper_input, phase_a_upper_input};
  assign lower_in = {phase_c_lower_input, phase_b_lower_input, phase_a_lower_input};

  // phase A upper is the pulse
  // Hall order A lower, B upper, B lower
  gdimd_commutate u_commutate
  (
    .pulse(phase_a_upper_input),
    .state_bits({phase_a_lower_input, phase_b_upper_input, phase_b_lower_input}),
    .direction(phase_c_upper_input),
    .async_rectify(s.async_rectify),
    .upper(table_upper),
    .lower(table_lower)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [2:0] fet;
  logic [2:0] gate_up;
  logic [2:0] gate_lo;
  logic [gdimd_pkg::AXI_DATA_W-1:0] read_word;
  logic read_hit;
  logic write_hit;

  // Gate decode, register writes and bus handshakes in one pass
  always_comb
  begin
    next_s = s;
    fet = fet_phases(s.mode);
    gate_up = 3'h0;
    gate_lo = 3'h0;
    read_word = '0;
    read_hit = 1'b0;
    write_hit = 1'b0;

    case (s.mode)
      gdimd_pkg::MODE_SIX_INPUT:
      begin
        // Both inputs high is treated as high impedance, never shoot-through
        gate_up = upper_in & ~lower_in;
        gate_lo = lower_in & ~upper_in;
      end
      gdimd_pkg::MODE_SINGLE_PULSE:
      begin
        // pin held high when braking is unused
        if (!phase_c_lower_input)
        begin
          gate_up = 3'h0;
          gate_lo = gdimd_pkg::PH_ALL;
        end
        else if (s.stop_select == gdimd_pkg::STOP_BRAKE)
        begin
          gate_up = 3'h0;
          gate_lo = gdimd_pkg::PH_ALL;
        end
        else if (s.stop_select == gdimd_pkg::STOP_COAST)
        begin
          gate_up = 3'h0;
          gate_lo = 3'h0;
        end
        else
        begin
          gate_up = table_upper;
          gate_lo = table_lower;
        end
      end
      default:
      begin
        // Three-input, half-bridge, mixed and independent modes
        for (int i = 0; i < 3; i++)
        begin
          if (fet[i])
          begin
            gate_up[i] = upper_in[i];
            gate_lo[i] = lower_in[i];
          end
          else
          begin
            gate_up[i] = lower_in[i] & upper_in[i];
            gate_lo[i] = lower_in[i] & ~upper_in[i];
          end
        end
      end
    endcase

    // gates, bypass and fault scope update together
    next_s.upper = gate_up;
    next_s.lower = gate_lo;
    next_s.bypass = fet;
    // per-FET fault handling on independent phases
    next_s.per_fet = fet;
    // both monitors active on independent phases
    next_s.mon_upper = fet | gate_up;
    next_s.mon_lower = fet | gate_lo;

    // Write address and data are captured independently, in either order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end

    // Commit once both halves are in and the previous response is gone
    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = gdimd_pkg::RESP_OKAY;
      if (addr_is(s.aw_addr, gdimd_pkg::CTRL_OFFSET))
      begin
        write_hit = 1'b1;
        // All control fields sit in byte lane 0
        if (s.w_strb[0])
        begin
          next_s.mode = gdimd_pkg::gdimd_mode_e'(s.w_data[gdimd_pkg::CTRL_MODE_LSB +: 3]);
          next_s.async_rectify = s.w_data[gdimd_pkg::CTRL_ASYNC_BIT];
          next_s.stop_select = s.w_data[gdimd_pkg::CTRL_STOP_LSB +: 2];
        end
      end
      else if (addr_is(s.aw_addr, gdimd_pkg::STATUS_OFFSET) ||
               addr_is(s.aw_addr, gdimd_pkg::INPUTS_OFFSET))
      begin
        // Read-only words accept and drop the write
        write_hit = 1'b1;
      end
      if (!write_hit)
      begin
        next_s.bresp = gdimd_pkg::RESP_SLVERR;
      end
    end

    // Write response leaves on its handshake
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end

    // One write in flight: channels reopen only when no response waits
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;

    // Read mux; reserved bits read as zero
    if (addr_is(s_axi_araddr, gdimd_pkg::CTRL_OFFSET))
    begin
      read_hit = 1'b1;
      read_word[gdimd_pkg::CTRL_MODE_LSB +: 3] = s.mode;
      read_word[gdimd_pkg::CTRL_ASYNC_BIT] = s.async_rectify;
      read_word[gdimd_pkg::CTRL_STOP_LSB +: 2] = s.stop_select;
    end
    else if (addr_is(s_axi_araddr, gdimd_pkg::STATUS_OFFSET))
    begin
      read_hit = 1'b1;
      read_word = status_word(s);
    end
    else if (addr_is(s_axi_araddr, gdimd_pkg::INPUTS_OFFSET))
    begin
      read_hit = 1'b1;
      read_word[gdimd_pkg::IN_UPPER_LSB +: 3] = upper_in;
      read_word[gdimd_pkg::IN_LOWER_LSB +: 3] = lower_in;
    end

    // Read address accepted only while no read data waits
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = read_word;
      next_s.rresp = read_hit ? gdimd_pkg::RESP_OKAY : gdimd_pkg::RESP_SLVERR;
    end
    else if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset forces safe all-off gates; clock enable low freezes everything
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s <= '0;
      s.mode <= gdimd_pkg::gdimd_mode_e'(gdimd_pkg::CTRL_MODE_RESET);
      s.async_rectify <= gdimd_pkg::CTRL_ASYNC_RESET;
      s.stop_select <= gdimd_pkg::CTRL_STOP_RESET;
    end
    else if (clock_enable)
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign upper_gate_output = s.upper;
  assign lower_gate_output = s.lower;
  assign dead_time_bypass = s.bypass;
  assign per_fet_fault_handling = s.per_fet;
  assign drain_source_overcurrent_monitor_upper = s.mon_upper;
  assign drain_source_overcurrent_monitor_lower = s.mon_lower;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;

endmodule

// File: verification/gdimd_props.sv
// Port checks for the gate drive input mode decoder
`timescale 1ns/100ps
module gdimd_props
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clock_enable,
  input wire logic phase_a_upper_input,
  input wire logic phase_a_lower_input,
  input wire logic [2:0] upper_gate_output,
  input wire logic [2:0] lower_gate_output,
  input wire logic [2:0] dead_time_bypass,
  input wire logic [2:0] drain_source_overcurrent_monitor_upper,
  input wire logic [2:0] drain_source_overcurrent_monitor_lower,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  sequence s_write_taken;
    clock_enable && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_read_taken;
    clock_enable && s_axi_arvalid && s_axi_arready;
  endsequence

  a_mon_enable: assert property (
    drain_source_overcurrent_monitor_upper == (upper_gate_output | dead_time_bypass)
    && drain_source_overcurrent_monitor_lower == (lower_gate_output | dead_time_bypass))
    else $error("Monitor enable wrong");

  a_indep_follow: assert property (
    $past(clock_enable) && dead_time_bypass[0] |->
    upper_gate_output[0] == $past(phase_a_upper_input)
    && lower_gate_output[0] == $past(phase_a_lower_input))
    else $error("Independent phase A gate wrong");

  a_bridge_no_shoot: assert property (
    (upper_gate_output & lower_gate_output & ~dead_time_bypass) == 3'h0)
    else $error("Both gates on in a bridge phase");

  // Reset overrides the usual disable, so it carries its own
  a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0)
    srst |=> upper_gate_output == 3'h0 && lower_gate_output == 3'h0
    && !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
    else $error("Outputs not quiet after reset");

  a_write_answer: assert property (
    s_write_taken ##1 clock_enable |=> s_axi_bvalid)
    else $error("Write response late");

  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");

  a_read_answer: assert property (
    s_read_taken |=> s_axi_rvalid)
    else $error("Read data late");

  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped");

  a_freeze_gates: assert property (
    !clock_enable |=> $stable(upper_gate_output) && $stable(lower_gate_output))
    else $error("Gates moved while frozen");
endmodule

// File: verification/gdimd_ctrl_model.sv
// Motor controller model driving the six phase inputs
`timescale 1ns/100ps
module gdimd_ctrl_model
(
  input wire logic clock,
  input wire logic single_pulse,
  input wire logic pulse,
  input wire logic [2:0] hall_state,
  input wire logic direction,
  input wire logic brake_n,
  input wire logic [2:0] raw_upper,
  input wire logic [2:0] raw_lower,
  output logic [2:0] upper_pins,
  output logic [2:0] lower_pins
);
  initial
  begin
    upper_pins = 3'h0;
    lower_pins = 3'h0;
  end

  // Pins change just after the edge, like a real controller output
  always @(posedge clock)
  begin
    if (single_pulse)
    begin
      upper_pins <= {direction, hall_state[1], pulse};
      lower_pins <= {brake_n, hall_state[0], hall_state[2]};
    end
    else
    begin
      // both levels pass as the bench holds them
      upper_pins <= raw_upper;
      lower_pins <= raw_lower;
    end
  end
endmodule

// File: verification/gdimd_tb_top.sv
// Self-checking bench for the gate drive input mode decoder
`timescale 1ns/100ps
module gdimd_tb_top;
  localparam logic [23:0] SRC = 24'h2898A0;
  localparam logic [23:0] SNK = 24'hD14250;
  localparam logic [23:0] IND = 24'hF8C000;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clock_enable = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sp = 1'b0;
  logic pulse = 1'b0;
  logic dir = 1'b0;
  logic brk_n = 1'b1;
  logic [2:0] hall = 3'h0;
  logic [2:0] raw_up = 3'h0;
  logic [2:0] raw_lo = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [2:0] up_in, lo_in, up_g, lo_g, byp, pf, mon_up, mon_lo, key, ind;
  logic [5:0] eg;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  // 40 MHz clock
  always #12.5 clock = ~clock;

  gdimd_ctrl_model i_ctrl
  (
    .clock(clock), .single_pulse(sp), .pulse(pulse), .hall_state(hall), .direction(dir),
    .brake_n(brk_n), .raw_upper(raw_up), .raw_lower(raw_lo), .upper_pins(up_in),
    .lower_pins(lo_in)
  );

  gdimd_decoder i_dut
  (
    .clock(clock), .srst(srst), .clock_enable(clock_enable),
    .phase_a_upper_input(up_in[0]), .phase_b_upper_input(up_in[1]),
    .phase_c_upper_input(up_in[2]), .phase_a_lower_input(lo_in[0]),
    .phase_b_lower_input(lo_in[1]), .phase_c_lower_input(lo_in[2]),
    .upper_gate_output(up_g), .lower_gate_output(lo_g), .dead_time_bypass(byp),
    .per_fet_fault_handling(pf), .drain_source_overcurrent_monitor_upper(mon_up),
    .drain_source_overcurrent_monitor_lower(mon_lo),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid)
      @(posedge clock);
    // Late ready makes the slave hold its response one cycle
    bready <= 1'b1;
    @(posedge clock);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdw(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    // Late ready makes the slave hold its data one cycle
    rready <= 1'b1;
    @(posedge clock);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Inputs are idled before every mode change
  task automatic set_ctrl(input logic [31:0] v);
    @(posedge clock);
    sp <= 1'b0;
    raw_up <= 3'h0;
    raw_lo <= 3'h0;
    repeat (2) @(posedge clock);
    wr(8'h00, v);
    sp <= v[2:0] == 3'h2;
  endtask

  // Pin register plus gate register give two edges of latency
  task automatic drive(input logic [2:0] h, input logic [2:0] l, input logic p,
    input logic [2:0] st, input logic d, input logic b);
    @(posedge clock);
    raw_up <= h;
    raw_lo <= l;
    pulse <= p;
    hall <= st;
    dir <= d;
    brk_n <= b;
    repeat (3) @(posedge clock);
    #1;
  endtask

  function automatic logic [5:0] exp_gates(input logic [2:0] m, input logic [2:0] h,
    input logic [2:0] l);
    logic [2:0] i;
    i = IND[m*3 +: 3];
    if (m == 3'h0)
      return {l & ~h, h & ~l};
    return {(l & i) | (l & ~h & ~i), (h & i) | (h & l & ~i)};
  endfunction

  function automatic logic [5:0] exp_sp(input logic p, input logic [2:0] k, input logic ar);
    logic [2:0] s;
    s = SRC[k*3 +: 3];
    return {SNK[k*3 +: 3] | ((p || ar) ? 3'h0 : s), p ? s : 3'h0};
  endfunction

  // Cuts a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      conclude();
    end
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    rdw(8'h00);
    chk32(rd, 32'h0);
    wr(8'h00, 32'h3A);
    wr(8'h04, 32'h0);
    chk32({30'h0, resp}, 32'h0);
    rdw(8'h00);
    chk32(rd, 32'h3A);
    rdw(8'h0C);
    chk32({rd[29:0], resp}, 32'h2);
    $display("test registers done");
    for (int m = 0; m < 8; m++)
    begin
      if (m != 2)
      begin
        set_ctrl(32'(m));
        ind = IND[m*3 +: 3];
        for (int v = 0; v < 64; v++)
        begin
          drive(v[2:0], v[5:3], 1'b0, 3'h0, 1'b0, 1'b1);
          eg = exp_gates(m[2:0], v[2:0], v[5:3]);
          chk6({lo_g, up_g}, eg);
          chk6({mon_lo, mon_up}, eg | {ind, ind});
          chk6({3'h0, byp}, {3'h0, ind});
          if (m == 6)
            chk6({3'h0, pf}, 6'h06);
        end
      end
    end
    rdw(8'h04);
    chk32(rd & 32'h3F1FF, 32'h3F1FF);
    rdw(8'h08);
    chk32(rd, 32'h3F);
    $display("test bridge modes done");
    for (int a = 0; a < 2; a++)
    begin
      set_ctrl({28'h0, a[0], 3'h2});
      for (int v = 0; v < 32; v++)
      begin
        drive(3'h0, 3'h0, v[0], v[3:1], v[4], 1'b1);
        key = (v[4] && v[3:1] != 3'h0 && v[3:1] != 3'h7) ? ~v[3:1] : v[3:1];
        chk6({lo_g, up_g}, exp_sp(v[0], key, a[0]));
      end
    end
    drive(3'h0, 3'h0, 1'b1, 3'h5, 1'b1, 1'b0);
    chk6({lo_g, up_g}, 6'h38);
    set_ctrl(32'h12);
    drive(3'h0, 3'h0, 1'b1, 3'h5, 1'b0, 1'b1);
    chk6({lo_g, up_g}, 6'h38);
    set_ctrl(32'h22);
    drive(3'h0, 3'h0, 1'b1, 3'h5, 1'b0, 1'b1);
    chk6({lo_g, up_g}, 6'h00);
    drive(3'h0, 3'h0, 1'b1, 3'h5, 1'b0, 1'b0);
    chk6({lo_g, up_g}, 6'h38);
    $display("test single pulse done");
    @(posedge clock);
    clock_enable <= 1'b0;
    drive(3'h0, 3'h0, 1'b1, 3'h5, 1'b0, 1'b1);
    chk6({lo_g, up_g}, 6'h38);
    @(posedge clock);
    clock_enable <= 1'b1;
    drive(3'h0, 3'h0, 1'b1, 3'h5, 1'b0, 1'b1);
    chk6({lo_g, up_g}, 6'h00);
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    rdw(8'h00);
    chk32(rd, 32'h0);
    $display("test freeze and reset done");
    conclude();
  end
endmodule

bind gdimd_decoder gdimd_props i_props
(
  .clock(clock), .srst(srst), .clock_enable(clock_enable),
  .phase_a_upper_input(phase_a_upper_input), .phase_a_lower_input(phase_a_lower_input),
  .upper_gate_output(upper_gate_output), .lower_gate_output(lower_gate_output),
  .dead_time_bypass(dead_time_bypass),
  .drain_source_overcurrent_monitor_upper(drain_source_overcurrent_monitor_upper),
  .drain_source_overcurrent_monitor_lower(drain_source_overcurrent_monitor_lower),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
